/* File: hw/counter_mode_cfg.svh */
// Constants for the counter mode decode and sequencing control block.
`ifndef COUNTER_MODE_CFG_SVH
`define COUNTER_MODE_CFG_SVH
`define CM_ADDR_MODE 4'h0
`define CM_ADDR_LOAD 4'h1
`define CM_ADDR_HOLD 4'h2
`define CM_ADDR_CMD 4'h3
`define CM_ADDR_STATUS 4'h4
`define CM_ADDR_COUNT 4'h5
`define CM_GATE_LSB 13
`define CM_GATE_MSB 15
`define CM_SPECIAL_BIT 7
`define CM_RELOAD_BIT 6
`define CM_REPEAT_BIT 5
`define CM_GATE_NONE 3'h0
`define CM_GATE_LEVEL 3'h1
`define CM_GATE_EDGE 3'h2
`define CM_CMD_ARM_BIT 0
`define CM_CMD_DISARM_BIT 1
`define CM_CMD_CAPTURE_BIT 2
`define CM_MODE_RESET 16'h0000
`define CM_LOAD_RESET 16'h0000
`define CM_HOLD_RESET 16'h0000
`define CM_COUNT_RESET 16'h0000
`endif

/* File: hw/counter_mode_decode_control.sv */
// Mode decode and sequencing control for one 16-bit down counter with an Avalon-MM slave.
`timescale 1ns/1ps
`include "counter_mode_cfg.svh"
module counter_mode_decode_control
  import counter_mode_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sourcePin,
  input wire logic gatePin,
  output logic terminalCount,
  output logic armed
);

  // Whole state of the block in one packed struct.
  typedef struct packed {
    logic [2:0] srcSync;
    logic [2:0] gateSync;
    logic [15:0] mode;
    logic [COUNT_W-1:0] load;
    logic [COUNT_W-1:0] hold;
    logic [COUNT_W-1:0] count;
    seq_state_t seq;
    logic useHold;
    logic tcSeen;
    logic stopPend;
    logic [31:0] rdata;
    logic ack;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Decodes the gate-control field into a gating kind.
  function automatic gate_kind_t gate_kind(input logic [2:0] field);
    case (field)
      `CM_GATE_NONE: gate_kind = GATE_NONE_K;
      `CM_GATE_LEVEL: gate_kind = GATE_LEVEL_K;
      `CM_GATE_EDGE: gate_kind = GATE_EDGE_K;
      default: gate_kind = GATE_NONE_K;
    endcase
  endfunction

  logic specialBit;
  logic reloadBit;
  logic repeatBit;
  gate_kind_t gk;
  logic srcEdge;
  logic gateLevel;
  logic gateEdge;
  logic atTc;
  logic busWrite;
  logic busRead;

  // Mode fields, synchronised pin edges and bus strobes.
  assign specialBit = s_q.mode[`CM_SPECIAL_BIT];
  assign reloadBit = s_q.mode[`CM_RELOAD_BIT];
  assign repeatBit = s_q.mode[`CM_REPEAT_BIT];
  assign gk = gate_kind(s_q.mode[`CM_GATE_MSB:`CM_GATE_LSB]);
  assign srcEdge = s_q.srcSync[1] & ~s_q.srcSync[2];
  assign gateEdge = s_q.gateSync[1] & ~s_q.gateSync[2];
  assign gateLevel = s_q.gateSync[1];
  assign atTc = (s_q.count == '0);
  // Writes take effect only at the edge where waitrequest is already low.
  assign busWrite = avs_write & s_q.ack;
  assign busRead = avs_read & ~s_q.ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata = s_q.rdata;
  assign terminalCount = atTc & (s_q.seq == ST_COUNTING);
  assign armed = (s_q.seq != ST_DISARMED);

  // Next-state logic for synchronisers, sequencer, datapath and bus slave.
  always_comb begin
    logic doCount;
    logic leaveTc;
    logic finish;
    doCount = 1'b0;
    leaveTc = 1'b0;
    finish = 1'b0;
    s_d = s_q;
    s_d.srcSync = {s_q.srcSync[1:0], sourcePin};
    s_d.gateSync = {s_q.gateSync[1:0], gatePin};
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    // A counting counter at terminal count always counts, whatever the gating says; so does one with a stop pending.
    if (srcEdge) begin
      if (s_q.stopPend) begin
        doCount = 1'b1;
      end else if (s_q.seq == ST_COUNTING) begin
        if (atTc) begin
          doCount = 1'b1;
        end else if (gk == GATE_LEVEL_K) begin
          doCount = gateLevel;
        end else begin
          doCount = 1'b1;
        end
      end
    end
    if (doCount) begin
      if (atTc) begin
        leaveTc = 1'b1;
        if (!reloadBit) begin
          s_d.count = s_q.load;
        end else if (specialBit) begin
          if (gk == GATE_NONE_K) begin
            s_d.count = gateLevel ? s_q.hold : s_q.load;
          end else begin
            s_d.count = s_q.load;
          end
        end else begin
          s_d.count = s_q.useHold ? s_q.hold : s_q.load;
          s_d.useHold = ~s_q.useHold;
        end
      end else begin
        s_d.count = s_q.count - 1'b1;
      end
    end
    // Stop or disarm decisions are applied as the counter leaves terminal count.
    if (leaveTc) begin
      s_d.stopPend = 1'b0;
      if (s_q.stopPend) begin
        // A software disarm pending at terminal count must not be undone by a repeat mode.
        finish = 1'b1;
      end else if (repeatBit) begin
        finish = 1'b0;
        if (gk == GATE_EDGE_K && !specialBit && reloadBit && !s_q.tcSeen) begin
          s_d.tcSeen = 1'b1;
        end else if (gk == GATE_EDGE_K && !(specialBit && reloadBit)) begin
          s_d.seq = ST_WAIT_EDGE;
          s_d.tcSeen = 1'b0;
        end
      end else if (reloadBit && (!specialBit || gk == GATE_NONE_K) && !s_q.tcSeen) begin
        s_d.tcSeen = 1'b1;
      end else begin
        finish = 1'b1;
      end
      if (finish) begin
        s_d.seq = ST_DISARMED;
        s_d.tcSeen = 1'b0;
      end
    end
    // Gate edges start edge-gated counts and drive the capture modes.
    if (gateEdge && s_q.seq != ST_DISARMED) begin
      if (s_q.seq == ST_WAIT_EDGE) begin
        s_d.seq = ST_COUNTING;
      end else if (specialBit && !reloadBit && gk != GATE_NONE_K) begin
        s_d.hold = s_q.count;
        s_d.count = s_q.load;
      end else if (specialBit && reloadBit && repeatBit && gk == GATE_EDGE_K) begin
        s_d.hold = s_q.count;
      end
    end
    // Register writes and commands.
    if (busWrite) begin
      case (avs_address)
        `CM_ADDR_MODE: s_d.mode = avs_writedata[15:0];
        `CM_ADDR_LOAD: s_d.load = avs_writedata[COUNT_W-1:0];
        `CM_ADDR_HOLD: s_d.hold = avs_writedata[COUNT_W-1:0];
        `CM_ADDR_CMD: begin
          if (avs_writedata[`CM_CMD_ARM_BIT]) begin
            s_d.seq = (gk == GATE_EDGE_K) ? ST_WAIT_EDGE : ST_COUNTING;
            s_d.tcSeen = 1'b0;
            s_d.stopPend = 1'b0;
            s_d.useHold = 1'b1; // Count starts from Load, so the first reload is Hold.
          end else if (avs_writedata[`CM_CMD_DISARM_BIT]) begin
            s_d.seq = ST_DISARMED;
            s_d.stopPend = atTc & (s_q.seq == ST_COUNTING);
          end
          if (avs_writedata[`CM_CMD_CAPTURE_BIT]) begin
            s_d.hold = s_q.count;
          end
        end
        `CM_ADDR_COUNT: s_d.count = avs_writedata[COUNT_W-1:0];
        default: begin
        end
      endcase
    end
    // Read data is latched at the request and stands with the acknowledge.
    if (busRead) begin
      case (avs_address)
        `CM_ADDR_MODE: s_d.rdata = {16'h0000, s_q.mode};
        `CM_ADDR_LOAD: s_d.rdata = 32'(s_q.load);
        `CM_ADDR_HOLD: s_d.rdata = 32'(s_q.hold);
        `CM_ADDR_STATUS: s_d.rdata = {28'h0000000, s_q.useHold, s_q.tcSeen,
                                      s_q.seq == ST_WAIT_EDGE, s_q.seq != ST_DISARMED};
        `CM_ADDR_COUNT: s_d.rdata = 32'(s_q.count);
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.mode <= `CM_MODE_RESET;
      s_q.load <= `CM_LOAD_RESET;
      s_q.hold <= `CM_HOLD_RESET;
      s_q.count <= `CM_COUNT_RESET;
      s_q.seq <= ST_DISARMED;
    end else begin
      s_q <= s_d;
    end
  end

  // Disarmed counter with no stop pending never changes on source edges.
  a_disarm_holds: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.seq == ST_DISARMED && !s_q.stopPend && !busWrite && !gateEdge)
      |=> $stable(s_q.count))
    else $error("Disarmed counter changed its count.");

  // Level gating with gate low blocks counting, except on the edge that leaves terminal count.
  a_level_block: assert property (@(posedge sys_clk) disable iff (reset)
    (gk == GATE_LEVEL_K && !gateLevel && !s_q.stopPend && !busWrite && !gateEdge
      && !(srcEdge && atTc)) |=> $stable(s_q.count))
    else $error("Count moved while level gate was inactive.");

  // Plain reload mode loads from Load after terminal count.
  a_reload_load: assert property (@(posedge sys_clk) disable iff (reset)
    (srcEdge && atTc && s_q.seq == ST_COUNTING && !reloadBit && !busWrite && !gateEdge)
      |=> (s_q.count == $past(s_q.load)))
    else $error("Counter did not reload from Load.");

  // Single-shot mode disarms on leaving terminal count.
  a_once_disarm: assert property (@(posedge sys_clk) disable iff (reset)
    (srcEdge && atTc && s_q.seq == ST_COUNTING && !reloadBit && !repeatBit && !busWrite)
      |=> (s_q.seq == ST_DISARMED))
    else $error("Single count mode did not disarm.");

  // Repeat mode never disarms on terminal count.
  a_repeat_armed: assert property (@(posedge sys_clk) disable iff (reset)
    (srcEdge && atTc && s_q.seq == ST_COUNTING && repeatBit && !busWrite)
      |=> (s_q.seq != ST_DISARMED))
    else $error("Repeat mode disarmed.");

  // Double count mode survives the first terminal count.
  a_twice_first: assert property (@(posedge sys_clk) disable iff (reset)
    (srcEdge && atTc && s_q.seq == ST_COUNTING && reloadBit && !specialBit
      && !repeatBit && !s_q.tcSeen && !busWrite) |=> (s_q.seq == ST_COUNTING))
    else $error("Double count mode stopped at first terminal count.");

  // Double count mode disarms at the second terminal count.
  a_twice_second: assert property (@(posedge sys_clk) disable iff (reset)
    (srcEdge && atTc && s_q.seq == ST_COUNTING && reloadBit && !repeatBit && s_q.tcSeen
      && !busWrite) |=> (s_q.seq == ST_DISARMED))
    else $error("Double count mode did not disarm at the second terminal count.");

  // A disarm issued at terminal count disarms at once; the edge that leaves it still reloads and clears the pending stop.
  a_stop_pending: assert property (@(posedge sys_clk) disable iff (reset)
    (srcEdge && atTc && s_q.stopPend && !busWrite) |=> (s_q.seq == ST_DISARMED))
    else $error("Pending stop did not leave the counter disarmed.");

  // Retrigger capture copies the count into Hold and reloads.
  a_retrig_cap: assert property (@(posedge sys_clk) disable iff (reset)
    (gateEdge && s_q.seq == ST_COUNTING && specialBit && !reloadBit && gk != GATE_NONE_K
      && !srcEdge && !busWrite) |=> (s_q.hold == $past(s_q.count))
      && (s_q.count == $past(s_q.load)))
    else $error("Retrigger capture failed.");

  // Edge-started modes wait for a gate edge before counting.
  a_edge_wait: assert property (@(posedge sys_clk) disable iff (reset)
    (s_q.seq == ST_WAIT_EDGE && gateEdge && !busWrite) |=> (s_q.seq == ST_COUNTING))
    else $error("Gate edge did not start the count.");

  // Bus answers within one cycle.
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (reset)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("Bus request was not answered in time.");

  c_tc_reached: cover property (@(posedge sys_clk) disable iff (reset) terminalCount);
  c_capture: cover property (@(posedge sys_clk) disable iff (reset)
    gateEdge && specialBit && reloadBit && repeatBit && s_q.seq == ST_COUNTING);
  c_alt_hold: cover property (@(posedge sys_clk) disable iff (reset) s_q.useHold && armed);
  c_stop_pend: cover property (@(posedge sys_clk) disable iff (reset) s_q.stopPend && srcEdge);

endmodule

/* File: hw/counter_mode_pkg.sv */
// Types shared by the counter mode decode and sequencing control block.
package counter_mode_pkg;
  typedef enum logic [1:0] {
    GATE_NONE_K,
    GATE_LEVEL_K,
    GATE_EDGE_K,
    GATE_BAD_K
  } gate_kind_t;
  typedef enum {
    ST_DISARMED,
    ST_WAIT_EDGE,
    ST_COUNTING
  } seq_state_t;
endpackage

/* File: testbench/counter_mode_decode_control_bench.sv */
// Self-checking bench for the counter mode decode and sequencing control block.
`timescale 1ns/1ps
`include "counter_mode_cfg.svh"
module counter_mode_decode_control_bench;
  logic sys_clk;
  logic reset;
  logic [3:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic [31:0] rdData;
  logic avsWaitrequest;
  logic sourcePin;
  logic gatePin;
  logic terminalCount;
  logic armed;
  logic [15:0] dbl [2] = '{16'h0040, 16'h4040};
  int fails = 0;
  int samplesChecked = 0;
  counter_mode_decode_control dut (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .sourcePin(sourcePin), .gatePin(gatePin),
    .terminalCount(terminalCount), .armed(armed));
  pin_source_model far (.sys_clk(sys_clk), .sourcePin(sourcePin), .gatePin(gatePin));
  // Clock at a 4 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // One Avalon-MM access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= {16'h0000, d};
    @(posedge sys_clk);
    // Only waitrequest sampled low or the watchdog ends this wait.
    while (avsWaitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rdData = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk($sformatf("reg%0d", a), exp, rdData[15:0]);
  endtask
  task automatic ca(input logic exp);
    chk("armed", {15'h0000, exp}, {15'h0000, armed});
  endtask
  // Disarms, programs mode, Load, Hold and count, then arms.
  task automatic cfg(input logic [15:0] m, input logic [15:0] ld, input logic [15:0] hd,
                     input logic [15:0] ct);
    bus(1'b1, `CM_ADDR_CMD, 16'h0002);
    bus(1'b1, `CM_ADDR_MODE, m);
    bus(1'b1, `CM_ADDR_LOAD, ld);
    bus(1'b1, `CM_ADDR_HOLD, hd);
    bus(1'b1, `CM_ADDR_COUNT, ct);
    bus(1'b1, `CM_ADDR_CMD, 16'h0001);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
  // Main sequence of mode tests.
  initial begin
    reset = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h00000000;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    ca(1'b0);
    rc(`CM_ADDR_COUNT, 16'h0000);
    rc(4'hf, 16'h0000);
    cfg(16'h0000, 16'h0005, 16'h0000, 16'h0002);
    far.pulse(2, 4);
    chk("tc", 16'h0001, {15'h0000, terminalCount});
    ca(1'b1);
    far.pulse(1, 4);
    rc(`CM_ADDR_COUNT, 16'h0005);
    ca(1'b0);
    far.pulse(2, 3);
    rc(`CM_ADDR_COUNT, 16'h0005);
    $display("test single count done");
    cfg(16'h2000, 16'h0005, 16'h0000, 16'h0003);
    far.pulse(2, 4);
    rc(`CM_ADDR_COUNT, 16'h0003);
    far.gate(1'b1);
    far.pulse(1, 4);
    rc(`CM_ADDR_COUNT, 16'h0002);
    far.gate(1'b0);
    $display("test level gating done");
    cfg(16'h4000, 16'h0004, 16'h0000, 16'h0002);
    far.pulse(1, 4);
    rc(`CM_ADDR_COUNT, 16'h0002);
    far.gate(1'b1);
    far.pulse(3, 4);
    rc(`CM_ADDR_COUNT, 16'h0004);
    ca(1'b0);
    far.gate(1'b0);
    $display("test edge start done");
    cfg(16'h0020, 16'h0002, 16'h0000, 16'h0001);
    far.pulse(5, 5);
    rc(`CM_ADDR_COUNT, 16'h0002);
    ca(1'b1);
    $display("test repeat done");
    foreach (dbl[i]) begin
      cfg(dbl[i], 16'h0002, 16'h0003, 16'h0001);
      far.pulse(1, 4);
      rc(`CM_ADDR_COUNT, (i == 0) ? 16'h0000 : 16'h0001);
      if (i == 1) begin
        far.gate(1'b1);
        far.pulse(1, 4);
      end
      far.pulse(1, 4);
      rc(`CM_ADDR_COUNT, 16'h0003);
      ca(1'b1);
      far.pulse(4, 4);
      rc(`CM_ADDR_COUNT, 16'h0002);
      ca(1'b0);
      far.gate(1'b0);
      $display("test double count done");
    end
    cfg(16'h00e0, 16'h0002, 16'h0006, 16'h0001);
    far.pulse(2, 4);
    rc(`CM_ADDR_COUNT, 16'h0002);
    far.gate(1'b1);
    far.pulse(3, 4);
    rc(`CM_ADDR_COUNT, 16'h0006);
    ca(1'b1);
    far.gate(1'b0);
    $display("test gate-selected reload done");
    cfg(16'h2080, 16'h0005, 16'h0000, 16'h0005);
    far.gate(1'b1);
    far.pulse(2, 4);
    far.gate(1'b0);
    far.gate(1'b1);
    rc(`CM_ADDR_HOLD, 16'h0003);
    rc(`CM_ADDR_COUNT, 16'h0005);
    far.gate(1'b0);
    $display("test retrigger done");
    cfg(16'h40e0, 16'h0004, 16'h0000, 16'h0004);
    far.gate(1'b1);
    far.pulse(2, 4);
    far.gate(1'b0);
    far.gate(1'b1);
    rc(`CM_ADDR_HOLD, 16'h0002);
    far.pulse(1, 4);
    rc(`CM_ADDR_COUNT, 16'h0001);
    far.pulse(2, 4);
    rc(`CM_ADDR_COUNT, 16'h0004);
    ca(1'b1);
    $display("test capture on the fly done");
    far.gate(1'b0);
    cfg(16'h00c0, 16'h0002, 16'h0003, 16'h0001);
    far.pulse(2, 4);
    rc(`CM_ADDR_COUNT, 16'h0002);
    ca(1'b1);
    far.pulse(3, 4);
    ca(1'b0);
    $display("test gated double count done");
    cfg(16'h0020, 16'h0002, 16'h0000, 16'h0001);
    far.pulse(1, 4);
    bus(1'b1, `CM_ADDR_CMD, 16'h0002);
    ca(1'b0);
    far.pulse(2, 4);
    rc(`CM_ADDR_COUNT, 16'h0002);
    $display("test disarm at terminal count done");
    summarize();
  end
endmodule

/* File: testbench/pin_source_model.sv */
// Far-side model that drives the counter source and gate pins.
`timescale 1ns/1ps
module pin_source_model (
  input wire logic sys_clk,
  output logic sourcePin,
  output logic gatePin
);
  // Both pins idle low from time zero.
  initial begin
    sourcePin = 1'b0;
    gatePin = 1'b0;
  end
  // Sends n rising source edges, each level held w cycles, past the input synchroniser.
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      sourcePin <= 1'b1;
      repeat (w) @(posedge sys_clk);
      sourcePin <= 1'b0;
      repeat (w) @(posedge sys_clk);
    end
  endtask
  // Moves the gate level; only a low-to-high move is a gate edge.
  task automatic gate(input logic v);
    gatePin <= v;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
